//--- verilog/ltxg_defines.svh
// constants for the link transmit enable gating block
`ifndef LTXG_DEFINES_SVH
`define LTXG_DEFINES_SVH

// clock period of the system_on_chip_clock domain, in ns
`define LTXG_CLK_PERIOD_NS 4
// least off time between disable and re-enable, in ns
`define LTXG_MIN_OFF_NS 100
// least off time in whole cycles, rounded up
`define LTXG_MIN_OFF_CYC ((`LTXG_MIN_OFF_NS + `LTXG_CLK_PERIOD_NS - 1) / `LTXG_CLK_PERIOD_NS)
`define LTXG_OFF_W 8

// settling counts per link_speed_ratio
`define LTXG_CNT_W 18
`define LTXG_SETTLE_1_1 18'h07fff
`define LTXG_SETTLE_1_1P5 18'h0cfff
`define LTXG_SETTLE_1_2 18'h11fff
`define LTXG_SETTLE_1_4 18'h24fff

// link_speed_ratio encodings
`define LTXG_SPD_W 2
`define LTXG_SPD_1_1 2'h0
`define LTXG_SPD_1_1P5 2'h1
`define LTXG_SPD_1_2 2'h2
`define LTXG_SPD_1_4 2'h3

`endif

//--- verilog/ltxg_pkg.sv
// types shared by the link transmit enable gating block
package ltxg_pkg;

	// transmitter gating state
	typedef enum logic [1:0] {
		ST_OFF,
		ST_SETTLE,
		ST_READY
	} ltxg_state_t;

	// link_tx_status_reg image
	typedef struct packed {
		logic tx_ready_vacant_flag;
		logic settling;
		logic offtime_err;
	} ltxg_status_t;

endpackage

//--- verilog/ltxg_settle_cnt.sv
// settling cycle counter, restarted from zero on each start
`timescale 1ns/100ps
`include "ltxg_defines.svh"

module ltxg_settle_cnt (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [`LTXG_CNT_W-1:0] i_target,
	output logic [`LTXG_CNT_W-1:0] o_count,
	output logic o_done
);
	logic [`LTXG_CNT_W-1:0] cnt_reg;
	logic [`LTXG_CNT_W-1:0] cnt_next;
	logic run_reg;
	logic run_next;
	logic done_reg;
	logic done_next;
	wire last = run_reg && (cnt_reg == i_target - `LTXG_CNT_W'(1));

	// start wins over abort so a fresh enable is never dropped
	assign cnt_next = i_start ? '0 : (run_reg ? cnt_reg + `LTXG_CNT_W'(1) : cnt_reg);
	assign run_next = i_start ? 1'b1 : ((i_abort || last) ? 1'b0 : run_reg);
	assign done_next = i_start ? 1'b0 : (i_abort ? 1'b0 : (done_reg || last));

	// counter state, frozen while clock enable is low
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (i_ce) begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
			done_reg <= done_next;
		end
	end

	assign o_count = cnt_reg;
	assign o_done = done_reg;
endmodule

//--- verilog/ltxg_top.sv
// link transmitter enable gating: off time check, dll settling, vacant flag
`timescale 1ns/100ps
`include "ltxg_defines.svh"

// Functional notes
// R1: controller keeps transmitter off at least 100 ns
// R2: settle 0x07FFF or 0x0CFFF cycles at 1:1/1:1.5
// R3: settle 0x11FFF or 0x24FFF cycles at 1:2/1:4
// R4: vacant flag rises only after settling finishes
// R5: dma transfers held off until settling ends
// R6: enable restarts count; disable aborts, clears vacant
module ltxg_top #(
	parameter logic [`LTXG_CNT_W-1:0] SETTLE_1_1 = `LTXG_SETTLE_1_1,
	parameter logic [`LTXG_CNT_W-1:0] SETTLE_1_1P5 = `LTXG_SETTLE_1_1P5,
	parameter logic [`LTXG_CNT_W-1:0] SETTLE_1_2 = `LTXG_SETTLE_1_2,
	parameter logic [`LTXG_CNT_W-1:0] SETTLE_1_4 = `LTXG_SETTLE_1_4
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_tx_enable,
	input wire logic [`LTXG_SPD_W-1:0] i_link_speed_ratio,
	input wire logic i_dma_req,
	output logic o_dma_grant,
	output logic o_tx_ready_vacant_flag,
	output ltxg_pkg::ltxg_status_t o_link_tx_status_reg,
	output logic o_offtime_violation,
	input wire logic i_link_clk,
	output logic o_link_tx_active
);
	logic en_prev_reg;
	logic [`LTXG_OFF_W-1:0] off_cnt_reg;
	logic [`LTXG_OFF_W-1:0] off_cnt_next;
	logic viol_reg;
	logic viol_sticky_reg;
	ltxg_pkg::ltxg_state_t state_reg;
	ltxg_pkg::ltxg_state_t state_next;
	ltxg_pkg::ltxg_status_t status_reg;
	logic [`LTXG_CNT_W-1:0] target;
	logic [`LTXG_CNT_W-1:0] count;
	logic settle_done;

	// enable rise and enable low level, taken only on enabled clocks
	wire start = i_ce && i_tx_enable && !en_prev_reg;
	wire abort = i_ce && !i_tx_enable;
	wire off_short = off_cnt_reg < `LTXG_OFF_W'(`LTXG_MIN_OFF_CYC);

	// last count seen one edge early, so vacant rises exactly target edges after start
	wire settle_last = (count == target - `LTXG_CNT_W'(1));

	// settling target per speed ratio
	function automatic logic [`LTXG_CNT_W-1:0] settle_of(input logic [`LTXG_SPD_W-1:0] link_speed_ratio);
		logic [`LTXG_CNT_W-1:0] t;
		t = SETTLE_1_4;
		if (link_speed_ratio == `LTXG_SPD_1_1) t = SETTLE_1_1; // see R2
		else if (link_speed_ratio == `LTXG_SPD_1_1P5) t = SETTLE_1_1P5; // see R2
		else if (link_speed_ratio == `LTXG_SPD_1_2) t = SETTLE_1_2; // see R3
		return t; // see R3
	endfunction

	assign target = settle_of(i_link_speed_ratio);

	// one counter; a ratio change mid-count takes the new target at once
	ltxg_settle_cnt u_cnt (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_start(start),
		.i_abort(abort),
		.i_target(target),
		.o_count(count),
		.o_done(settle_done)
	);

	// gating state, next value
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ltxg_pkg::ST_OFF: begin
				if (start) state_next = ltxg_pkg::ST_SETTLE; // see R6
			end
			ltxg_pkg::ST_SETTLE: begin
				if (!i_tx_enable) state_next = ltxg_pkg::ST_OFF; // see R6
				else if (settle_done || settle_last) state_next = ltxg_pkg::ST_READY; // see R4
			end
			ltxg_pkg::ST_READY: begin
				if (!i_tx_enable) state_next = ltxg_pkg::ST_OFF; // see R6
			end
			// fourth code of the two-bit state is unused; fall back to off
			default: begin
				state_next = ltxg_pkg::ST_OFF;
			end
		endcase
	end

	// off time counter saturates, cleared while enabled
	assign off_cnt_next = i_tx_enable ? '0 :
		(off_short ? off_cnt_reg + `LTXG_OFF_W'(1) : off_cnt_reg);

	// state and edge registers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_reg <= ltxg_pkg::ST_OFF;
			en_prev_reg <= 1'b0;
			off_cnt_reg <= `LTXG_OFF_W'(`LTXG_MIN_OFF_CYC);
			viol_reg <= 1'b0;
			viol_sticky_reg <= 1'b0;
		end else if (i_ce) begin
			state_reg <= state_next;
			en_prev_reg <= i_tx_enable;
			off_cnt_reg <= off_cnt_next;
			viol_reg <= start && off_short; // see R1
			viol_sticky_reg <= viol_sticky_reg || (start && off_short); // see R1
		end
	end

	// status image; vacant only in ready, which a disable leaves on the next enabled clock
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			status_reg <= '0;
		end else if (i_ce) begin
			status_reg.tx_ready_vacant_flag <= (state_next == ltxg_pkg::ST_READY); // see R4
			status_reg.settling <= (state_next == ltxg_pkg::ST_SETTLE);
			status_reg.offtime_err <= viol_sticky_reg || (start && off_short);
		end
	end

	assign o_tx_ready_vacant_flag = status_reg.tx_ready_vacant_flag;
	assign o_link_tx_status_reg = status_reg;
	assign o_offtime_violation = viol_reg;
	// dma grant held off until the vacant flag is set
	assign o_dma_grant = i_dma_req && status_reg.tx_ready_vacant_flag; // see R5

	// link clock domain: reset and vacant level cross by two flops each
	logic lrst_s1_reg;
	logic lrst_s2_reg;
	logic vac_s1_reg;
	logic vac_s2_reg;
	logic active_reg;

	always_ff @(posedge i_link_clk) begin
		lrst_s1_reg <= i_srst;
		lrst_s2_reg <= lrst_s1_reg;
	end

	// the link side only launches once the dll has settled
	always_ff @(posedge i_link_clk) begin
		if (lrst_s2_reg) begin
			vac_s1_reg <= 1'b0;
			vac_s2_reg <= 1'b0;
			active_reg <= 1'b0;
		end else begin
			vac_s1_reg <= status_reg.tx_ready_vacant_flag;
			vac_s2_reg <= vac_s1_reg;
			active_reg <= vac_s2_reg; // see R4
		end
	end

	assign o_link_tx_active = active_reg;

	// checks
	// a flag frozen by a low clock enable may outlive a disable
	a_vacant_needs_en: assert property (@(posedge i_clk) disable iff (i_srst) // see R6
		(o_tx_ready_vacant_flag && $past(i_ce)) |-> $past(i_tx_enable))
		else $error("vacant set without enable");
	a_disable_clears: assert property (@(posedge i_clk) disable iff (i_srst) // see R6
		(i_ce && !i_tx_enable) |=> !o_tx_ready_vacant_flag)
		else $error("vacant survived a disable");
	a_start_zero: assert property (@(posedge i_clk) disable iff (i_srst) // see R6
		start |=> (count == '0) && !o_tx_ready_vacant_flag)
		else $error("count not restarted on enable");
	a_rise_on_count: assert property (@(posedge i_clk) disable iff (i_srst) // see R4
		$rose(o_tx_ready_vacant_flag) |-> $past(count) == $past(target) - `LTXG_CNT_W'(1))
		else $error("vacant rose before settling ended");
	a_target_fast: assert property (@(posedge i_clk) disable iff (i_srst) // see R2
		(i_link_speed_ratio == `LTXG_SPD_1_1 && target == SETTLE_1_1) ||
		(i_link_speed_ratio == `LTXG_SPD_1_1P5 && target == SETTLE_1_1P5) ||
		i_link_speed_ratio[1])
		else $error("wrong settling count for fast ratio");
	a_target_slow: assert property (@(posedge i_clk) disable iff (i_srst) // see R3
		(i_link_speed_ratio == `LTXG_SPD_1_2 && target == SETTLE_1_2) ||
		(i_link_speed_ratio == `LTXG_SPD_1_4 && target == SETTLE_1_4) ||
		!i_link_speed_ratio[1])
		else $error("wrong settling count for slow ratio");
	a_dma_gated: assert property (@(posedge i_clk) disable iff (i_srst) // see R5
		o_dma_grant |-> o_tx_ready_vacant_flag && i_dma_req && !o_link_tx_status_reg.settling)
		else $error("dma granted during settling");
	a_offtime_flag: assert property (@(posedge i_clk) disable iff (i_srst) // see R1
		(start && off_cnt_reg < `LTXG_OFF_W'(`LTXG_MIN_OFF_CYC)) |=> o_offtime_violation)
		else $error("short off time not flagged");
	a_link_follows: assert property (@(posedge i_link_clk) disable iff (lrst_s2_reg) // see R4
		$rose(o_link_tx_active) |-> $past(vac_s2_reg))
		else $error("link active without vacant");
	a_link_drop: assert property (@(posedge i_link_clk) disable iff (lrst_s2_reg) // see R4
		!vac_s2_reg |=> !o_link_tx_active)
		else $error("link stayed active after vacant fell");

	// flag and pulse shapes; a low clock enable holds every i_clk register
	a_freeze_holds: assert property (@(posedge i_clk) disable iff (i_srst) // see R4
		!i_ce |=> $stable(o_link_tx_status_reg) && $stable(o_offtime_violation))
		else $error("state moved while clock enable low");
	a_vacant_settled: assert property (@(posedge i_clk) disable iff (i_srst) // see R4
		$rose(o_tx_ready_vacant_flag) |-> $past(o_link_tx_status_reg.settling))
		else $error("vacant rose without a settling period");
	a_settle_excl: assert property (@(posedge i_clk) disable iff (i_srst) // see R4
		o_link_tx_status_reg.settling |-> !o_tx_ready_vacant_flag)
		else $error("vacant and settling both set");
	a_pulse_single: assert property (@(posedge i_clk) disable iff (i_srst) // see R1
		(o_offtime_violation && i_ce) |=> !o_offtime_violation)
		else $error("off time pulse longer than one cycle");
	a_pulse_sticky: assert property (@(posedge i_clk) disable iff (i_srst) // see R1
		o_offtime_violation |-> o_link_tx_status_reg.offtime_err)
		else $error("off time pulse without sticky bit");

	c_settle_done: cover property (@(posedge i_clk) disable iff (i_srst)
		$rose(o_tx_ready_vacant_flag));
	c_abort: cover property (@(posedge i_clk) disable iff (i_srst)
		o_link_tx_status_reg.settling && abort);
	c_short_off: cover property (@(posedge i_clk) disable iff (i_srst)
		o_offtime_violation);
	c_grant: cover property (@(posedge i_clk) disable iff (i_srst) o_dma_grant);
	c_freeze: cover property (@(posedge i_clk) disable iff (i_srst)
		!i_ce && o_tx_ready_vacant_flag);
endmodule

//--- verification/ltxg_link_rx.sv
// far-end link receiver model: follows the transmitter's active line on the link clock
`timescale 1ns/100ps
module ltxg_link_rx (
	input wire logic i_link_clk,
	input wire logic i_srst,
	input wire logic i_tx_active,
	output logic o_rx_up,
	output int o_rises
);
	// counts each time the sender comes up, so the bench sees every handover
	always_ff @(posedge i_link_clk) begin
		if (i_srst) begin
			o_rx_up <= 1'b0;
			o_rises <= 0;
		end else begin
			o_rx_up <= i_tx_active;
			if (i_tx_active && !o_rx_up) begin
				o_rises <= o_rises + 1;
			end
		end
	end
endmodule

//--- verification/test_ltxg_top.sv
// self-checking bench for the link transmit enable gating block
`timescale 1ns/100ps
`include "ltxg_defines.svh"
module test_ltxg_top;
	logic i_clk, i_srst, i_ce, i_tx_enable, i_dma_req, i_link_clk;
	logic [`LTXG_SPD_W-1:0] i_link_speed_ratio;
	logic o_dma_grant, o_tx_ready_vacant_flag, o_offtime_violation, o_link_tx_active, rx_up;
	ltxg_pkg::ltxg_status_t o_link_tx_status_reg;
	int rx_rises, err_count, total_checks;
	int cyc = 0;
	// shortened settling counts keep the run brief
	localparam int T_TAB [4] = '{32'h14, 32'h1e, 32'h28, 32'h3c};

	ltxg_top #(.SETTLE_1_1(18'h14), .SETTLE_1_1P5(18'h1e), .SETTLE_1_2(18'h28),
		.SETTLE_1_4(18'h3c)) ltxg_top_i (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
		.i_tx_enable(i_tx_enable), .i_link_speed_ratio(i_link_speed_ratio),
		.i_dma_req(i_dma_req), .o_dma_grant(o_dma_grant),
		.o_tx_ready_vacant_flag(o_tx_ready_vacant_flag),
		.o_link_tx_status_reg(o_link_tx_status_reg), .o_offtime_violation(o_offtime_violation),
		.i_link_clk(i_link_clk), .o_link_tx_active(o_link_tx_active));
	ltxg_link_rx ltxg_link_rx_i (.i_link_clk(i_link_clk), .i_srst(i_srst),
		.i_tx_active(o_link_tx_active), .o_rx_up(rx_up), .o_rises(rx_rises));

	// system clock and an unrelated link clock
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		i_link_clk = 1'b0;
		#1.3;
		forever #6 i_link_clk = ~i_link_clk;
	end
	// hang guard
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic set_en(input logic v, input int wait_n);
		@(posedge i_clk);
		i_tx_enable <= v;
		repeat (wait_n) @(posedge i_clk);
	endtask
	// enable, keep dma asking, count edges until vacant; grant must track vacant
	task automatic settle(input logic [1:0] link_speed_ratio, output int n, output int gbad);
		@(posedge i_clk);
		i_link_speed_ratio <= link_speed_ratio;
		i_tx_enable <= 1'b1;
		i_dma_req <= 1'b1;
		n = 0;
		gbad = 0;
		while (n < 100 && o_tx_ready_vacant_flag !== 1'b1) begin
			@(posedge i_clk);
			#1;
			n++;
			if (o_dma_grant !== o_tx_ready_vacant_flag) gbad++;
		end
		repeat (20) @(posedge i_link_clk);
	endtask

	task automatic test_ratios;
		int n, g;
		for (int r = 0; r < 4; r++) begin
			settle(r[1:0], n, g);
			chk("settle_cycles", T_TAB[r] + 1, n);
			chk("status_vacant", 1'b1, o_link_tx_status_reg.tx_ready_vacant_flag);
			chk("dma_grant_gate", 0, g);
			chk("link_rx_rises", r + 1, rx_rises);
			set_en(1'b0, 40);
		end
		$display("ratios done");
	endtask
	task automatic test_abort;
		int n, g;
		set_en(1'b1, 6);
		#1;
		chk("settling_flag", 1'b1, o_link_tx_status_reg.settling);
		// wait past the full count of the ratio in use, so a missed abort would show
		set_en(1'b0, T_TAB[3] + 10);
		#1;
		chk("vacant_after_abort", 1'b0, o_tx_ready_vacant_flag);
		settle(2'h0, n, g);
		chk("restart_cycles", T_TAB[0] + 1, n);
		set_en(1'b0, 40);
		$display("abort done");
	endtask
	task automatic test_offtime;
		int n, g, pulses;
		settle(2'h1, n, g);
		chk("no_false_offtime", 1'b0, o_link_tx_status_reg.offtime_err);
		set_en(1'b0, 5);
		i_tx_enable <= 1'b1;
		pulses = 0;
		repeat (6) begin
			@(posedge i_clk);
			#1;
			if (o_offtime_violation === 1'b1) pulses++;
		end
		chk("offtime_pulses", 1, pulses);
		chk("offtime_sticky", 1'b1, o_link_tx_status_reg.offtime_err);
		set_en(1'b0, 40);
		$display("offtime done");
	endtask
	// clock enable low holds the flag across a disable; it drops once enable returns
	task automatic test_freeze;
		int n, g;
		settle(2'h0, n, g);
		chk("freeze_settle", T_TAB[0] + 1, n);
		@(posedge i_clk);
		i_ce <= 1'b0;
		i_tx_enable <= 1'b0;
		repeat (8) @(posedge i_clk);
		#1;
		chk("frozen_vacant", 1'b1, o_tx_ready_vacant_flag);
		@(posedge i_clk);
		i_ce <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		chk("thawed_vacant", 1'b0, o_tx_ready_vacant_flag);
		repeat (40) @(posedge i_clk);
		$display("freeze done");
	endtask

	initial begin
		i_srst = 1'b1;
		i_ce = 1'b1;
		i_tx_enable = 1'b0;
		i_dma_req = 1'b0;
		i_link_speed_ratio = 2'h0;
		err_count = 0;
		total_checks = 0;
		// five cycles span at least one link edge, which the link-side reset sync needs
		repeat (5) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		#1;
		chk("reset_outputs", 0, {o_tx_ready_vacant_flag, o_link_tx_status_reg, o_dma_grant});
		test_ratios();
		test_abort();
		test_freeze();
		test_offtime();
		wrap_up();
	end
endmodule
